// *** rtl/uibg_top.sv ***
// Top: interrupt enables, irq status, baud generator and clock pin control
//
// Contract
// - Stale data flag raises irq when enabled
// - Clear-to-send change raises irq when enabled
// - Clear-to-send level readable via transmitter status
// - Rx full enable resets 0, irq while full
// - Rx half enable resets 0, irq above half
// - Rx ready enable: irq while data present
// - Tx empty enable: irq while tx empty
// - Tx half enable resets 0, irq below half
// - Tx avail enable resets 0, irq on slot
// - Direction bit: clock pin input/output
// - Baud source: system clock or pin
// - Divide generator clock by two to field
// - Prescaler divides by 65 minus field
// - Stale after 30 bit times, clear on read
// - Sync 1x receive uses sixteen-x clock
//
// Decided for this implementation: the address-and-strobe port and the address map.
module uibg_top
(
    // Clock and reset
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_n_i,
    // Register port
    input  wire logic [uibg_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [uibg_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [uibg_pkg::DATA_W-1:0] rdata_o,
    // Receiver and transmitter state
    input  wire logic                        rx_full_i,
    input  wire logic                        rx_half_i,
    input  wire logic                        rx_ready_i,
    input  wire logic                        rx_char_read_i,
    input  wire logic                        tx_empty_i,
    input  wire logic                        tx_half_i,
    input  wire logic                        tx_avail_i,
    input  wire logic                        sync_1x_mode_i,
    // Pins
    input  wire logic                        clear_to_send_pin_i,
    input  wire logic                        ext_serial_clock_pin_i,
    output logic                             ext_serial_clock_pin_o,
    output logic                             ext_serial_clock_pin_oe_n_o,
    // Clock enables and interrupt
    output logic                             sixteen_x_clock_o,
    output logic                             rx_bit_clk_o,
    output logic                             irq_o
);
    import uibg_pkg::*;

    logic [EVT_N-1:0]  ctrl_q, ctrl_d;
    logic [15:0]       baud_q, baud_d;
    logic [EVT_N-1:0]  ist_q, ist_d;
    logic [EVT_N-1:0]  ien_q, ien_d;
    logic [15:0]       rdata_q, rdata_d;
    logic              cts_q, cts_d;
    logic              pin_q, pin_d;
    logic [6:0]        pre_cnt_q, pre_cnt_d;
    logic [6:0]        div_cnt_q, div_cnt_d;
    logic              tick16_q, tick16_d;
    logic              ucko_q, ucko_d;
    logic [3:0]        ovs_q, ovs_d;
    logic [4:0]        age_q, age_d;
    logic              stale_q, stale_d;
    logic [EVT_N-1:0]  cond;
    logic              src_tick;
    logic              pre_tick;
    logic [6:0]        pre_div;
    logic [6:0]        div_lim;
    logic              bit_tick;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        hit = (a == o);
    endfunction

    // Generator source: system clock every cycle or rising edge of the pin
    always_comb
    begin
        pin_d    = ext_serial_clock_pin_i;
        src_tick = baud_q[BIT_BAUDSRC] ? (ext_serial_clock_pin_i & ~pin_q) : 1'b1;
        pre_div  = PRE_BASE - {1'b0, baud_q[PRE_MSB:PRE_LSB]};
        div_lim  = 7'((8'h01 << baud_q[DIV_MSB:DIV_LSB]) - 8'h01);
        pre_cnt_d = pre_cnt_q;
        div_cnt_d = div_cnt_q;
        pre_tick  = 1'b0;
        tick16_d  = 1'b0;
        ucko_d    = ucko_q;
        if (src_tick)
        begin
            if (pre_cnt_q >= pre_div - 7'h01)
            begin
                pre_cnt_d = 7'h00;
                pre_tick  = 1'b1;
            end
            else
            begin
                pre_cnt_d = pre_cnt_q + 7'h01;
            end
        end
        if (pre_tick)
        begin
            if (div_cnt_q >= div_lim)
            begin
                div_cnt_d = 7'h00;
                tick16_d  = 1'b1;
                ucko_d    = ~ucko_q;
            end
            else
            begin
                div_cnt_d = div_cnt_q + 7'h01;
            end
        end
    end

    // Bit time from sixteen-x ticks; old data ages in bit times
    always_comb
    begin
        ovs_d    = tick16_q ? ovs_q + 4'h1 : ovs_q;
        bit_tick = tick16_q && (ovs_q == 4'(OVS - 1));
        age_d    = age_q;
        stale_d  = stale_q;
        if (!rx_ready_i || rx_char_read_i)
        begin
            age_d   = 5'h00;
            stale_d = 1'b0;
        end
        else if (bit_tick)
        begin
            if (age_q >= 5'(STALE_BITS))
                stale_d = 1'b1;
            else
                age_d = age_q + 5'h01;
        end
    end

    // Conditions and sticky status
    always_comb
    begin
        cts_d = clear_to_send_pin_i;
        cond[BIT_STALE]   = stale_q;
        cond[BIT_CLEAR_TO_SEND_DELTA_IRQ_EN]    = 1'b0;
        cond[BIT_RXFULL]  = rx_full_i;
        cond[BIT_RXHALF]  = rx_half_i;
        cond[BIT_RXRDY]   = rx_ready_i;
        cond[BIT_TXEMPTY] = tx_empty_i;
        cond[BIT_TXHALF]  = tx_half_i;
        cond[BIT_TXAVAIL] = tx_avail_i;
        ist_d = ist_q;
        if (wr_i && hit(addr_i, OFS_IRQ_CLEAR))
            ist_d = ist_q & ~wdata_i[EVT_N-1:0];
        // Set after clear so a same-cycle event survives
        ist_d[BIT_CLEAR_TO_SEND_DELTA_IRQ_EN] = ist_d[BIT_CLEAR_TO_SEND_DELTA_IRQ_EN] | (cts_q ^ clear_to_send_pin_i);
    end

    // Register writes and reads
    always_comb
    begin
        ctrl_d  = ctrl_q;
        baud_d  = baud_q;
        ien_d   = ien_q;
        rdata_d = 16'h0000;
        if (wr_i && hit(addr_i, OFS_STAT_CTRL))
            ctrl_d = wdata_i[EVT_N-1:0];
        // Reserved bits are dropped and read zero
        if (wr_i && hit(addr_i, OFS_BAUD_CTRL))
            baud_d = wdata_i & BAUD_WMASK;
        if (wr_i && hit(addr_i, OFS_IRQ_ENABLE))
            ien_d = wdata_i[EVT_N-1:0];
        if (rd_i)
        begin
            case (addr_i)
                OFS_STAT_CTRL:  rdata_d = {8'h00, ctrl_q};
                OFS_BAUD_CTRL:  rdata_d = baud_q;
                OFS_TX_STATUS:  rdata_d = 16'(cts_q) << TX_CTS_BIT;
                OFS_RX_STATUS:  rdata_d = {8'h00, cond};
                OFS_IRQ_STATUS: rdata_d = {8'h00, ist_q};
                OFS_IRQ_ENABLE: rdata_d = {8'h00, ien_q};
                default:        rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_q    <= CTRL_RESET;
            baud_q    <= BAUD_RESET;
            ist_q     <= 8'h00;
            ien_q     <= 8'h00;
            rdata_q   <= 16'h0000;
            // Pins sampled in reset so no false edge follows it
            cts_q     <= clear_to_send_pin_i;
            pin_q     <= ext_serial_clock_pin_i;
            pre_cnt_q <= 7'h00;
            div_cnt_q <= 7'h00;
            tick16_q  <= 1'b0;
            ucko_q    <= 1'b0;
            ovs_q     <= 4'h0;
            age_q     <= 5'h00;
            stale_q   <= 1'b0;
        end
        else
        begin
            ctrl_q    <= ctrl_d;
            baud_q    <= baud_d;
            ist_q     <= ist_d;
            ien_q     <= ien_d;
            rdata_q   <= rdata_d;
            cts_q     <= cts_d;
            pin_q     <= pin_d;
            pre_cnt_q <= pre_cnt_d;
            div_cnt_q <= div_cnt_d;
            tick16_q  <= tick16_d;
            ucko_q    <= ucko_d;
            ovs_q     <= ovs_d;
            age_q     <= age_d;
            stale_q   <= stale_d;
        end
    end

    // Level conditions gate directly; delta is sticky
    logic [EVT_N-1:0] act;
    always_comb
    begin
        act = cond;
        act[BIT_CLEAR_TO_SEND_DELTA_IRQ_EN] = ist_q[BIT_CLEAR_TO_SEND_DELTA_IRQ_EN];
    end

    assign irq_o   = |(act & ctrl_q) | |(ist_q & ien_q);
    assign rdata_o = rdata_q;
    // Pin select is outside this block; direction assumes it is zero
    assign ext_serial_clock_pin_oe_n_o = ~baud_q[BIT_CLKDIR];
    assign ext_serial_clock_pin_o      = ucko_q;
    assign sixteen_x_clock_o           = tick16_q;
    // Pin source is only meaningful with the pin as input
    assign rx_bit_clk_o = sync_1x_mode_i ? tick16_q : bit_tick;

    sequence s_cts_edge;
        clear_to_send_pin_i != cts_q;
    endsequence

    AST_CLEAR_TO_SEND_DELTA_IRQ_EN_STICKY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_cts_edge |=> ist_q[BIT_CLEAR_TO_SEND_DELTA_IRQ_EN])
        else $error("cts delta not latched");
    AST_CLEAR_TO_SEND_DELTA_IRQ_EN_IRQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (ist_q[BIT_CLEAR_TO_SEND_DELTA_IRQ_EN] && ctrl_q[BIT_CLEAR_TO_SEND_DELTA_IRQ_EN]) |-> irq_o)
        else $error("cts irq missing");
    AST_STALE_IRQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (stale_q && ctrl_q[BIT_STALE]) |-> irq_o)
        else $error("stale irq missing");
    AST_RXFULL_IRQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (rx_full_i && ctrl_q[BIT_RXFULL]) |-> irq_o)
        else $error("rx full irq missing");
    AST_RXHALF_IRQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (rx_half_i && ctrl_q[BIT_RXHALF]) |-> irq_o)
        else $error("rx half irq missing");
    AST_RXRDY_IRQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (rx_ready_i && ctrl_q[BIT_RXRDY]) |-> irq_o)
        else $error("rx ready irq missing");
    AST_TX_IRQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        ((tx_empty_i && ctrl_q[BIT_TXEMPTY]) || (tx_half_i && ctrl_q[BIT_TXHALF])
         || (tx_avail_i && ctrl_q[BIT_TXAVAIL])) |-> irq_o)
        else $error("tx irq missing");
    AST_NO_IRQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (ctrl_q == 8'h00 && ien_q == 8'h00) |-> !irq_o)
        else $error("irq without enable");
    AST_DIR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (wr_i && hit(addr_i, OFS_BAUD_CTRL)) |=> (ext_serial_clock_pin_oe_n_o
         == !$past(wdata_i[BIT_CLKDIR])))
        else $error("pin direction wrong");
    AST_STALE_CLR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rx_char_read_i |=> !stale_q)
        else $error("stale not cleared");
    AST_DIV1: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (baud_q == 16'h003F && pre_tick)
        |=> !pre_tick ##1 (pre_tick || baud_q != 16'h003F))
        else $error("prescaler wrong");
    AST_SYNC: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        sync_1x_mode_i |-> (rx_bit_clk_o == sixteen_x_clock_o))
        else $error("1x bit clock wrong");

    sequence s_stale_rise;
        !stale_q ##1 stale_q;
    endsequence

    AST_STALE_AGE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_stale_rise |-> ($past(age_q) == 5'(STALE_BITS)))
        else $error("stale set too early");
    AST_CTS_QUIET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (clear_to_send_pin_i == cts_q && !(wr_i && hit(addr_i, OFS_IRQ_CLEAR)))
        |=> $stable(ist_q[BIT_CLEAR_TO_SEND_DELTA_IRQ_EN]))
        else $error("cts delta without pin change");
    AST_TICK_ONE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        sixteen_x_clock_o |=> !sixteen_x_clock_o)
        else $error("sixteen-x tick too long");
    AST_RXBIT_16X: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (!sync_1x_mode_i && rx_bit_clk_o) |-> sixteen_x_clock_o)
        else $error("bit clock off tick");
    AST_BAUD_RSVD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (rd_i && hit(addr_i, OFS_BAUD_CTRL)) |=> ((rdata_o & ~BAUD_WMASK) == 16'h0000))
        else $error("reserved baud bits read back");
endmodule

// *** rtl/uibg_pkg.sv ***
// Package: register map, field positions and timing constants for the UART irq/baud block
package uibg_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 16;
    localparam logic [3:0]  OFS_STAT_CTRL   = 4'h0;
    localparam logic [3:0]  OFS_BAUD_CTRL   = 4'h1;
    localparam logic [3:0]  OFS_TX_STATUS   = 4'h2;
    localparam logic [3:0]  OFS_RX_STATUS   = 4'h3;
    localparam logic [3:0]  OFS_IRQ_STATUS  = 4'h4;
    localparam logic [3:0]  OFS_IRQ_ENABLE  = 4'h5;
    localparam logic [3:0]  OFS_IRQ_CLEAR   = 4'h6;
    localparam int          BIT_STALE       = 7;
    localparam int          BIT_CLEAR_TO_SEND_DELTA_IRQ_EN        = 6;
    localparam int          BIT_RXFULL      = 5;
    localparam int          BIT_RXHALF      = 4;
    localparam int          BIT_RXRDY       = 3;
    localparam int          BIT_TXEMPTY     = 2;
    localparam int          BIT_TXHALF      = 1;
    localparam int          BIT_TXAVAIL     = 0;
    localparam int          BIT_CLKDIR      = 13;
    localparam int          BIT_BAUDSRC     = 11;
    localparam int          DIV_LSB         = 8;
    localparam int          DIV_MSB         = 10;
    localparam int          PRE_LSB         = 0;
    localparam int          PRE_MSB         = 5;
    localparam logic [15:0] BAUD_WMASK      = 16'h2F3F;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [15:0] BAUD_RESET      = 16'h0000;
    localparam logic [6:0]  PRE_BASE        = 7'h41;
    localparam int          TX_CTS_BIT      = 15;
    localparam int          STALE_BITS      = 30;
    localparam int          OVS             = 16;
    localparam int          EVT_N           = 8;
endpackage

// *** bench/uibg_peer.sv ***
// Far-side model: external serial clock source on the clock pin
module uibg_peer
(
    // Clock and control
    input  wire logic sys_clk_i,
    input  wire logic run_i,
    // Pin
    input  wire logic pin_oe_n_i,
    output logic      ext_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_q = 2'h0;
    logic       clk_q = 1'b0;
    assign ext_clk_o = clk_q;
    // Drives only while the pin is an input, else stands still
    always @(posedge sys_clk_i)
    begin
        if (run_i && pin_oe_n_i)
        begin
            div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
            if (div_q == 2'h2)
                clk_q <= ~clk_q;
        end
    end
endmodule

// *** bench/uart_irq_enable_baud_gen_tb.sv ***
// Testbench for the UART irq enable and baud generator block
module uart_irq_enable_baud_gen_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import uibg_pkg::*;
    logic        sys_clk_i, rst_n_i, wr_i, rd_i, rd_ch, s1x, cts, run;
    logic        irq_o, tick, bclk, pin_o, oe_n, pclk, p;
    logic [3:0]  addr_i;
    logic [5:0]  fst;
    logic [15:0] wdata_i, rdata_o, v;
    logic [14:0] rows [10];
    logic [15:0] brow [5];
    int          fails, tests_run, n, g;
    uibg_top uibg_top_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rx_full_i(fst[5]), .rx_half_i(fst[4]), .rx_ready_i(fst[3]),
        .rx_char_read_i(rd_ch), .tx_empty_i(fst[2]), .tx_half_i(fst[1]),
        .tx_avail_i(fst[0]), .sync_1x_mode_i(s1x), .clear_to_send_pin_i(cts),
        .ext_serial_clock_pin_i(oe_n ? pclk : pin_o), .ext_serial_clock_pin_o(pin_o),
        .ext_serial_clock_pin_oe_n_o(oe_n), .sixteen_x_clock_o(tick),
        .rx_bit_clk_o(bclk), .irq_o(irq_o));
    uibg_peer uibg_peer_i (.sys_clk_i(sys_clk_i), .run_i(run), .pin_oe_n_i(oe_n),
        .ext_clk_o(pclk));
    initial
    begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end
    task automatic test_done();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic settle();
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_irq(input int lim);
        for (n = 0; n < lim && irq_o !== 1'b1; n++)
            @(negedge sys_clk_i);
        chk(16'(irq_o), 16'h0001);
        if (irq_o !== 1'b1)
            test_done();
    endtask
    // Gap between two sixteen-x pulses, bounded wait
    task automatic tick_gap();
        int c, seen;
        seen = 0;
        g = 0;
        for (c = 0; c < 3000 && seen < 2; c++)
        begin
            @(negedge sys_clk_i);
            if (seen == 1)
                g++;
            if (tick === 1'b1)
                seen++;
        end
        if (seen < 2)
        begin
            fails++;
            $display("BAD t=%0t no sixteen-x tick", $time);
            test_done();
        end
    endtask
    initial
    begin
        rst_n_i = 0; wr_i = 0; rd_i = 0; addr_i = 0; wdata_i = 0; fst = 0;
        rd_ch = 0; s1x = 0; cts = 0; run = 0; fails = 0; tests_run = 0;
        // Rows: enables, live conditions, expected irq
        rows = '{{8'h01, 6'h01, 1'b1}, {8'h02, 6'h02, 1'b1}, {8'h04, 6'h04, 1'b1},
                 {8'h08, 6'h08, 1'b1}, {8'h10, 6'h10, 1'b1}, {8'h20, 6'h20, 1'b1},
                 {8'h1F, 6'h20, 1'b0}, {8'h3E, 6'h01, 1'b0}, {8'h00, 6'h3F, 1'b0},
                 {8'h21, 6'h3F, 1'b1}};
        // Rows: divide, prescaler, expected tick period
        brow = '{{3'h0, 6'h3F, 7'h02}, {3'h2, 6'h3C, 7'h14}, {3'h0, 6'h00, 7'h41},
                 {3'h3, 6'h3E, 7'h18}, {3'h7, 6'h3F, 7'h00}};
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rd(OFS_STAT_CTRL);
        chk(v, 16'h0000);
        rd(OFS_BAUD_CTRL);
        chk({v[15:1], oe_n}, 16'h0001);
        rd(4'hF);
        chk(v, 16'h0000);
        for (int r = 0; r < 10; r++)
        begin
            wr(OFS_STAT_CTRL, {8'h00, rows[r][14:7]});
            fst <= rows[r][6:1];
            settle();
            chk(16'(irq_o), 16'(rows[r][0]));
        end
        for (int r = 0; r < 5; r++)
        begin
            wr(OFS_BAUD_CTRL, {5'h00, brow[r][15:13], 2'h0, brow[r][12:7]});
            tick_gap();
            tick_gap();
            // Divide 128 with divisor 2 overflows seven bits, so zero means 256
            chk(16'(g), (brow[r][6:0] == 0) ? 16'h0100 : 16'(brow[r][6:0]));
        end
        // Stale data: 30 bit times at 2 cycles a tick is 960 cycles
        wr(OFS_BAUD_CTRL, 16'h003F);
        // Drop ready first so aging starts from zero
        fst <= 6'h00;
        wr(OFS_STAT_CTRL, 16'h0080);
        fst <= 6'h08;
        repeat (900) @(posedge sys_clk_i);
        #1 chk(16'(irq_o), 16'h0000);
        wait_irq(200);
        wr(OFS_STAT_CTRL, 16'h0000);
        settle();
        chk(16'(irq_o), 16'h0000);
        rd_ch <= 1'b1;
        @(posedge sys_clk_i);
        rd_ch <= 1'b0;
        wr(OFS_STAT_CTRL, 16'h0080);
        settle();
        chk(16'(irq_o), 16'h0000);
        fst <= 6'h00;
        // Clear-to-send change, masked then enabled, sticky then cleared
        wr(OFS_STAT_CTRL, 16'h0000);
        cts <= 1'b1;
        repeat (4) settle();
        chk(16'(irq_o), 16'h0000);
        rd(OFS_TX_STATUS);
        chk(16'(v[TX_CTS_BIT]), 16'h0001);
        wr(OFS_IRQ_CLEAR, 16'h0040);
        wr(OFS_STAT_CTRL, 16'h0040);
        settle();
        chk(16'(irq_o), 16'h0000);
        cts <= 1'b0;
        wait_irq(10);
        rd(OFS_TX_STATUS);
        chk(16'(v[TX_CTS_BIT]), 16'h0000);
        wr(OFS_IRQ_CLEAR, 16'h0040);
        settle();
        chk(16'(irq_o), 16'h0000);
        wr(OFS_STAT_CTRL, 16'h0000);
        wr(OFS_IRQ_ENABLE, 16'h0040);
        cts <= 1'b1;
        wait_irq(10);
        rd(OFS_IRQ_STATUS);
        chk(16'(v[BIT_CLEAR_TO_SEND_DELTA_IRQ_EN]), 16'h0001);
        wr(OFS_IRQ_CLEAR, 16'h0040);
        settle();
        chk(16'(irq_o), 16'h0000);
        // Reserved bits dropped, pin turned to output
        wr(OFS_BAUD_CTRL, 16'hFFFF);
        rd(OFS_BAUD_CTRL);
        chk(v, BAUD_WMASK);
        chk(16'(oe_n), 16'h0000);
        // Pin source: rising edge every 6 cycles, divisor 2 gives 12
        wr(OFS_BAUD_CTRL, 16'h083F);
        run <= 1'b1;
        tick_gap();
        tick_gap();
        chk(16'(g), 16'h000C);
        run <= 1'b0;
        wr(OFS_BAUD_CTRL, 16'h003F);
        s1x <= 1'b1;
        @(negedge sys_clk_i);
        p = pin_o;
        repeat (20)
        begin
            @(negedge sys_clk_i);
            chk(16'(bclk), 16'(tick));
            chk(16'(pin_o), 16'(p ^ tick));
            p = pin_o;
        end
        // Mid-run reset: enables, direction and cts history come back clean
        wr(OFS_STAT_CTRL, 16'h00FF);
        wr(OFS_BAUD_CTRL, 16'h2000);
        rst_n_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rd(OFS_STAT_CTRL);
        chk(v, 16'h0000);
        chk(16'(oe_n), 16'h0001);
        rd(OFS_IRQ_STATUS);
        chk(v, 16'h0000);
        chk(16'(irq_o), 16'h0000);
        test_done();
    end
endmodule
